// ### itb_core_model.sv
// partner model: the core side of the vectored call handshake
// assumes one clock and one reset shared with the unit under test
`timescale 1ns/1ps
module itb_core_model #(
  parameter int RET_DELAY = 30
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench control
  input wire logic hold_stack,
  // unit side
  input wire logic irq_call,
  output logic stack_full,
  output logic return_from_irq
);
  logic [7:0] cnt_r;
  // each routine runs a fixed time and ends with a re-arming return
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= 8'h00;
      return_from_irq <= 1'b0;
    end
    else
    begin
      return_from_irq <= (cnt_r == 8'h01);
      if (irq_call)
        cnt_r <= 8'(RET_DELAY);
      else if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
    end
  end
  // the stack fills only when the bench asks, one cycle late like a core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stack_full <= 1'b0;
    else
      stack_full <= hold_stack;
  end
endmodule

// ### itb_pkg.sv
// constants for the interrupt and time base unit
// assumes a single 20 MHz system clock and a word-wide AHB-Lite register bus
package itb_pkg;

  localparam int NPIN = 6;
  localparam int NSRC = 11;
  localparam int NAUX = 11;
  localparam int NGRP = 4;
  localparam int TB_CNT_W = 15;
  localparam int TB_BASE_EXP = 8;
  localparam int CLK_HZ = 20000000;

  // register byte offsets
  localparam logic [5:0] OFS_IRQ_CTRL = 6'h00;
  localparam logic [5:0] OFS_PIN_EN = 6'h04;
  localparam logic [5:0] OFS_EDGE_SEL = 6'h08;
  localparam logic [5:0] OFS_IRQ_FLAGS = 6'h0C;
  localparam logic [5:0] OFS_AUX_FLAGS = 6'h10;
  localparam logic [5:0] OFS_AUX_EN = 6'h14;
  localparam logic [5:0] OFS_PSC_SRC = 6'h18;
  localparam logic [5:0] OFS_TB0_CTRL = 6'h1C;
  localparam logic [5:0] OFS_TB1_CTRL = 6'h20;

  // irq control fields
  localparam int CTL_GIE = 0;
  localparam int CTL_GRP_LSB = 1;
  localparam int CTL_CONV_EN = 5;
  localparam int CTL_TB0_EN = 6;
  localparam int CTL_TB1_EN = 7;
  localparam int CTL_W = 8;

  // irq flag fields
  localparam int FLG_CONV = 6;
  localparam int FLG_TB0 = 7;
  localparam int FLG_TB1 = 8;
  localparam int FLG_GRP_LSB = 9;
  localparam int FLG_W = 13;

  // aux sources: [0] ptm0 P [1] ptm0 A [2] ptm1 P [3] ptm1 A
  // [4] stm P [5] stm A [6] atm P [7] atm A [8] atm B [9] eeprom
  // [10] low voltage
  localparam logic [10:0] GRP0_MASK = 11'h00F;
  localparam logic [10:0] GRP1_MASK = 11'h630;
  localparam logic [10:0] GRP2_MASK = 11'h1C0;
  localparam int GRP3_PIN_LO = 2;
  localparam int GRP3_PIN_HI = 3;

  // time base control fields
  localparam int TBC_RUN = 7;
  localparam int TBC_PER_W = 3;
  localparam int PSC_SRC_W = 2;
  localparam int PSC_SUB_BIT = 1;

  // edge select codes, two bits per pin
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [1:0] PSC_SYS = 2'h0;
  localparam logic [1:0] PSC_DIV4 = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // vector numbers, lowest number wins
  localparam logic [3:0] VEC_PIN0 = 4'h0;
  localparam logic [3:0] VEC_PIN1 = 4'h1;
  localparam logic [3:0] VEC_PIN4 = 4'h2;
  localparam logic [3:0] VEC_PIN5 = 4'h3;
  localparam logic [3:0] VEC_CONV = 4'h4;
  localparam logic [3:0] VEC_MF0 = 4'h5;
  localparam logic [3:0] VEC_TB0 = 4'h9;
  localparam logic [3:0] VEC_TB1 = 4'hA;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### itb_top.sv
// interrupt request, vectoring and dual time base unit
// assumes an AHB-Lite master with one transfer outstanding, synchronous
// source pulses and pins, and a core that takes irq_call as a vectored call
`timescale 1ns/1ps
module itb_top (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // external pins and their port setup
  input wire logic [itb_pkg::NPIN-1:0] ext_irq_pins,
  input wire logic [itb_pkg::NPIN-1:0] pin_func_sel,
  input wire logic [itb_pkg::NPIN-1:0] port_dir_in,
  input wire logic [itb_pkg::NPIN-1:0] pull_high_sel,
  output logic [itb_pkg::NPIN-1:0] pull_high_en,
  // peripheral events, one-cycle pulses, and the sub clock
  input wire logic conv_done,
  input wire logic eeprom_done,
  input wire logic low_voltage_detector,
  input wire logic [8:0] timer_match,
  input wire logic sub_clk,
  // processor core
  input wire logic stack_full,
  input wire logic return_from_irq,
  output logic irq_call,
  output logic [3:0] irq_vector,
  output logic wakeup
);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // lowest set bit as a one-hot word
  function automatic logic [itb_pkg::NSRC-1:0] lowest_one(
    input logic [itb_pkg::NSRC-1:0] v);
    lowest_one = v & (~v + 11'h001);
  endfunction

  function automatic logic [3:0] onehot_index(
    input logic [itb_pkg::NSRC-1:0] v);
    onehot_index = 4'h0;
    for (int k = 0; k < itb_pkg::NSRC; k++)
    begin
      if (v[k])
        onehot_index = k[3:0];
    end
  endfunction

  function automatic logic [itb_pkg::TB_CNT_W-1:0] period_mask(
    input logic [itb_pkg::TBC_PER_W-1:0] code);
    period_mask = 15'h7FFF >> (3'h7 - code);
  endfunction

  logic [itb_pkg::CTL_W-1:0] ctl_r;
  logic [itb_pkg::NPIN-1:0] pin_en_r;
  logic [2*itb_pkg::NPIN-1:0] edge_sel_r;
  logic [itb_pkg::NAUX-1:0] aux_en_r;
  logic [itb_pkg::PSC_SRC_W-1:0] psc_src_r;
  logic [7:0] tbc_r [2];
  logic [itb_pkg::NPIN-1:0] ext_flag_r;
  logic conv_flag_r;
  logic [1:0] tb_flag_r;
  logic [itb_pkg::NGRP-1:0] grp_flag_r;
  logic [itb_pkg::NAUX-1:0] aux_flag_r;
  logic [itb_pkg::NPIN-1:0] pin_prev_r;
  logic sub_prev_r;
  logic [1:0] div4_r;
  logic [itb_pkg::TB_CNT_W-1:0] tb_cnt_r [2];
  logic wr_pend_r;
  logic [5:0] wr_addr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic irq_call_r;
  logic [3:0] irq_vector_r;
  logic wakeup_r;
  logic [itb_pkg::NPIN-1:0] pull_high_r;

  logic gie;
  logic [itb_pkg::NPIN-1:0] pin_active;
  logic [itb_pkg::NPIN-1:0] ext_evt;
  logic [itb_pkg::NAUX-1:0] aux_evt;
  logic [itb_pkg::NGRP-1:0] grp_evt;
  logic [1:0] tb_ovf;
  logic psc_tick;
  logic [itb_pkg::NSRC-1:0] pend;
  logic [itb_pkg::NSRC-1:0] svc;
  logic grant;
  logic wr_en;
  logic rd_take;
  logic [31:0] wdat;
  logic [itb_pkg::FLG_W-1:0] flags_all;

  assign gie = ctl_r[itb_pkg::CTL_GIE];
  assign wr_en = wr_pend_r & clk_en;
  assign wdat = hwdata;
  assign rd_take = clk_en & hsel & hready & htrans[1] & ~hwrite;
  assign aux_evt = {low_voltage_detector, eeprom_done, timer_match};

  // ---------------- external pins ----------------
  genvar gp;
  generate
    for (gp = 0; gp < itb_pkg::NPIN; gp++)
    begin : g_pin
      logic rise;
      logic fall;
      logic [1:0] mode;
      assign rise = ext_irq_pins[gp] & ~pin_prev_r[gp];
      assign fall = ~ext_irq_pins[gp] & pin_prev_r[gp];
      assign mode = edge_sel_r[2*gp +: 2];
      assign pin_active[gp] = pin_en_r[gp] & pin_func_sel[gp] &
                              port_dir_in[gp];
      assign ext_evt[gp] = pin_active[gp] &
        ((rise & (mode == itb_pkg::EDGE_RISE)) |
         (fall & (mode == itb_pkg::EDGE_FALL)) |
         ((rise | fall) & (mode == itb_pkg::EDGE_BOTH)));
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_prev_r <= '0;
    else if (clk_en)
      pin_prev_r <= ext_irq_pins;
  end

  // pull-high is never overridden by the interrupt function
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pull_high_r <= '0;
    else if (clk_en)
      pull_high_r <= pull_high_sel;
  end

  // ---------------- prescaler and time bases ----------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div4_r <= '0;
      sub_prev_r <= 1'b0;
    end
    else if (clk_en)
    begin
      div4_r <= div4_r + 2'h1;
      sub_prev_r <= sub_clk;
    end
  end

  // sub clock is far slower than hclk, so its rising edge is a tick
  always_comb
  begin
    if (psc_src_r[itb_pkg::PSC_SUB_BIT])
      psc_tick = sub_clk & ~sub_prev_r;
    else if (psc_src_r == itb_pkg::PSC_DIV4)
      psc_tick = (div4_r == itb_pkg::DIV4_LAST);
    else
      psc_tick = 1'b1;
  end

  genvar gt;
  generate
    for (gt = 0; gt < 2; gt++)
    begin : g_tb
      logic run;
      logic [itb_pkg::TB_CNT_W-1:0] mask;
      assign run = tbc_r[gt][itb_pkg::TBC_RUN];
      assign mask = period_mask(tbc_r[gt][itb_pkg::TBC_PER_W-1:0]);
      assign tb_ovf[gt] = run & psc_tick & ((tb_cnt_r[gt] & mask) == mask);
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          tb_cnt_r[gt] <= '0;
        else if (clk_en)
        begin
          if (!run)
            tb_cnt_r[gt] <= '0;
          else if (psc_tick)
            tb_cnt_r[gt] <= tb_cnt_r[gt] + 15'h0001;
        end
      end
    end
  endgenerate

  // ---------------- request pending and vectoring ----------------
  assign grp_evt[0] = |(aux_evt & aux_en_r & itb_pkg::GRP0_MASK);
  assign grp_evt[1] = |(aux_evt & aux_en_r & itb_pkg::GRP1_MASK);
  assign grp_evt[2] = |(aux_evt & aux_en_r & itb_pkg::GRP2_MASK);
  assign grp_evt[3] = |(ext_evt[itb_pkg::GRP3_PIN_HI:itb_pkg::GRP3_PIN_LO] &
                        pin_en_r[itb_pkg::GRP3_PIN_HI:itb_pkg::GRP3_PIN_LO]);

  assign pend = {tb_flag_r[1] & ctl_r[itb_pkg::CTL_TB1_EN],
                 tb_flag_r[0] & ctl_r[itb_pkg::CTL_TB0_EN],
                 grp_flag_r & ctl_r[itb_pkg::CTL_GRP_LSB +: itb_pkg::NGRP],
                 conv_flag_r & ctl_r[itb_pkg::CTL_CONV_EN],
                 ext_flag_r[5] & pin_en_r[5],
                 ext_flag_r[4] & pin_en_r[4],
                 ext_flag_r[1] & pin_en_r[1],
                 ext_flag_r[0] & pin_en_r[0]};

  assign grant = clk_en & gie & ~stack_full & (|pend);
  assign svc = grant ? lowest_one(pend) : '0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_call_r <= 1'b0;
      irq_vector_r <= '0;
    end
    else if (clk_en)
    begin
      irq_call_r <= grant;
      if (grant)
        irq_vector_r <= onehot_index(svc);
    end
  end

  // ---------------- request flags ----------------
  // a hardware set always beats a service or software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_flag_r <= '0;
      conv_flag_r <= 1'b0;
      tb_flag_r <= '0;
      grp_flag_r <= '0;
    end
    else if (clk_en)
    begin
      // pins 2,3 have no service clear
      ext_flag_r <= (ext_flag_r & ~{svc[3], svc[2], 2'b00, svc[1], svc[0]} &
        ~((wr_en && wr_addr_r == itb_pkg::OFS_IRQ_FLAGS) ?
          wdat[itb_pkg::NPIN-1:0] : '0)) | ext_evt;
      conv_flag_r <= (conv_flag_r & ~svc[itb_pkg::VEC_CONV] &
        ~(wr_en && wr_addr_r == itb_pkg::OFS_IRQ_FLAGS &&
          wdat[itb_pkg::FLG_CONV])) | conv_done;
      tb_flag_r <= (tb_flag_r & ~svc[itb_pkg::VEC_TB1:itb_pkg::VEC_TB0] &
        ~((wr_en && wr_addr_r == itb_pkg::OFS_IRQ_FLAGS) ?
          wdat[itb_pkg::FLG_TB1:itb_pkg::FLG_TB0] : 2'b00)) | tb_ovf;
      grp_flag_r <= (grp_flag_r & ~svc[itb_pkg::VEC_MF0 +: itb_pkg::NGRP] &
        ~((wr_en && wr_addr_r == itb_pkg::OFS_IRQ_FLAGS) ?
          wdat[itb_pkg::FLG_GRP_LSB +: itb_pkg::NGRP] : '0)) | grp_evt;
    end
  end

  // member flags are never cleared by service, only by software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aux_flag_r <= '0;
    else if (clk_en)
      aux_flag_r <= (aux_flag_r &
        ~((wr_en && wr_addr_r == itb_pkg::OFS_AUX_FLAGS) ?
          wdat[itb_pkg::NAUX-1:0] : '0)) | aux_evt;
  end

  assign flags_all = {grp_flag_r, tb_flag_r, conv_flag_r, ext_flag_r};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wakeup_r <= 1'b0;
    else if (clk_en)
      wakeup_r <= |(ext_evt & ~ext_flag_r) | (conv_done & ~conv_flag_r) |
                  |(tb_ovf & ~tb_flag_r) | |(grp_evt & ~grp_flag_r) |
                  |(aux_evt & ~aux_flag_r);
  end

  // ---------------- control registers ----------------
  // return from irq wins over the service clear of the global enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctl_r <= '0;
    else if (clk_en)
    begin
      if (wr_en && wr_addr_r == itb_pkg::OFS_IRQ_CTRL)
        ctl_r <= wdat[itb_pkg::CTL_W-1:0];
      if (return_from_irq)
        ctl_r[itb_pkg::CTL_GIE] <= 1'b1;
      else if (grant)
        ctl_r[itb_pkg::CTL_GIE] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_en_r <= '0;
      edge_sel_r <= '0;
      aux_en_r <= '0;
    end
    else if (wr_en)
    begin
      if (wr_addr_r == itb_pkg::OFS_PIN_EN)
        pin_en_r <= wdat[itb_pkg::NPIN-1:0];
      if (wr_addr_r == itb_pkg::OFS_EDGE_SEL)
        edge_sel_r <= wdat[2*itb_pkg::NPIN-1:0];
      if (wr_addr_r == itb_pkg::OFS_AUX_EN)
        aux_en_r <= wdat[itb_pkg::NAUX-1:0];
    end
  end

  // unimplemented bits are never stored, so they read back zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      psc_src_r <= '0;
      tbc_r[0] <= '0;
      tbc_r[1] <= '0;
    end
    else if (wr_en)
    begin
      if (wr_addr_r == itb_pkg::OFS_PSC_SRC)
        psc_src_r <= wdat[itb_pkg::PSC_SRC_W-1:0];
      if (wr_addr_r == itb_pkg::OFS_TB0_CTRL)
        tbc_r[0] <= {wdat[itb_pkg::TBC_RUN], 4'h0,
                     wdat[itb_pkg::TBC_PER_W-1:0]};
      if (wr_addr_r == itb_pkg::OFS_TB1_CTRL)
        tbc_r[1] <= {wdat[itb_pkg::TBC_RUN], 4'h0,
                     wdat[itb_pkg::TBC_PER_W-1:0]};
    end
  end

  // ---------------- bus slave ----------------
  // zero wait states: read data is captured at the address phase, so a
  // read issued in the data phase of a write would see the old value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hreadyout_r <= 1'b1;
    end
    else if (clk_en)
    begin
      wr_pend_r <= hsel & hready & htrans[1] & hwrite;
      wr_addr_r <= {haddr[5:2], 2'b00};
      hreadyout_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= '0;
    else if (rd_take)
    begin
      unique case ({haddr[5:2], 2'b00})
        itb_pkg::OFS_IRQ_CTRL: hrdata_r <= {24'h0, ctl_r};
        itb_pkg::OFS_PIN_EN: hrdata_r <= {26'h0, pin_en_r};
        itb_pkg::OFS_EDGE_SEL: hrdata_r <= {20'h0, edge_sel_r};
        itb_pkg::OFS_IRQ_FLAGS: hrdata_r <= {19'h0, flags_all};
        itb_pkg::OFS_AUX_FLAGS: hrdata_r <= {21'h0, aux_flag_r};
        itb_pkg::OFS_AUX_EN: hrdata_r <= {21'h0, aux_en_r};
        itb_pkg::OFS_PSC_SRC: hrdata_r <= {30'h0, psc_src_r};
        itb_pkg::OFS_TB0_CTRL: hrdata_r <= {24'h0, tbc_r[0]};
        itb_pkg::OFS_TB1_CTRL: hrdata_r <= {24'h0, tbc_r[1]};
        default: hrdata_r <= '0;
      endcase
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = itb_pkg::HRESP_OKAY;
  assign irq_call = irq_call_r;
  assign irq_vector = irq_vector_r;
  assign wakeup = wakeup_r;
  assign pull_high_en = pull_high_r;

  // ---------------- checks ----------------
  AST_CALL_GATED: assert property (
    $rose(irq_call_r) |-> $past(gie) && !$past(stack_full))
    else $error("call made without global enable or with stack full");

  AST_GIE_CLEARED: assert property (
    $rose(irq_call_r) && !$past(return_from_irq) |-> !gie)
    else $error("global enable not cleared on service");

  AST_RETURN_SETS: assert property (
    clk_en && return_from_irq |=> gie)
    else $error("return from irq did not set global enable");

  AST_PRIORITY: assert property (
    $rose(irq_call_r) |->
      ($past(pend) & ~(11'h7FF << irq_vector_r)) == 11'h000)
    else $error("a lower vector was pending but not taken");

  AST_PIN_QUAL: assert property (
    clk_en && $rose(ext_flag_r[0]) |->
      $past(pin_active[0]) && $past(edge_sel_r[1:0]) != itb_pkg::EDGE_OFF)
    else $error("pin flag set while pin not an active interrupt input");

  AST_TB_STOPPED: assert property (
    clk_en && !tbc_r[0][itb_pkg::TBC_RUN] |=> tb_cnt_r[0] == 15'h0000
      && !tb_flag_r[0] || $past(tb_flag_r[0]))
    else $error("stopped time base counted or overflowed");

  AST_MEMBERS_KEPT: assert property (
    $rose(irq_call_r) && !$past(wr_en) |->
      (aux_flag_r & $past(aux_flag_r)) == $past(aux_flag_r))
    else $error("group member flag cleared by service");

  AST_WAKE: assert property (
    $past(clk_en) && |(flags_all & ~$past(flags_all)) |-> wakeup_r)
    else $error("flag rose without wake-up");

  AST_PSC_ZERO: assert property (
    rd_take && {haddr[5:2], 2'b00} == itb_pkg::OFS_PSC_SRC |=>
      hrdata_r[31:2] == 30'h0)
    else $error("unimplemented prescaler bits read nonzero");

endmodule

// ### test_interrupt_and_time_base_unit.sv
// self-checking bench for the interrupt and time base unit
// assumes the core model returns 30 cycles after each call
`timescale 1ns/1ps
module test_interrupt_and_time_base_unit;
  typedef struct packed {
    logic [17:0] m;
    logic [3:0] v;
    logic [12:0] f;
    logic [10:0] a;
  } itb_row_t;
  localparam int LIMIT = 20000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [17:0] ev = 18'h0;
  logic [5:0] fsel = 6'h3F;
  logic [1:0] subdiv = 2'h0;
  logic hold = 1'b0;
  logic ce = 1'b1;
  logic hreadyout, hresp, irq_call, wakeup, stack_full, ret, hit;
  logic [31:0] hrdata;
  logic [5:0] phe;
  logic [3:0] vec;
  int cycles = 0;
  int wake_cnt = 0;
  int w0;
  int comparisons = 0;
  int miscompares = 0;
  // pins 0..5, conv, eeprom, low voltage, then timer matches 0..8
  itb_row_t rows [13] = '{
    '{18'h00001, 4'h0, 13'h000, 11'h000},
    '{18'h00002, 4'h1, 13'h000, 11'h000},
    '{18'h00004, 4'h8, 13'h004, 11'h000},
    '{18'h00008, 4'h8, 13'h008, 11'h000},
    '{18'h00010, 4'h2, 13'h000, 11'h000},
    '{18'h00020, 4'h3, 13'h000, 11'h000},
    '{18'h00040, 4'h4, 13'h000, 11'h000},
    '{18'h00080, 4'h6, 13'h000, 11'h200},
    '{18'h00100, 4'h6, 13'h000, 11'h400},
    '{18'h00200, 4'h5, 13'h000, 11'h001},
    '{18'h01000, 4'h5, 13'h000, 11'h008},
    '{18'h02000, 4'h6, 13'h000, 11'h010},
    '{18'h20000, 4'h7, 13'h000, 11'h100}};

  itb_top DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ext_irq_pins(ev[5:0]),
    .pin_func_sel(fsel), .port_dir_in(6'h3F), .pull_high_sel(6'h2A),
    .pull_high_en(phe), .conv_done(ev[6]), .eeprom_done(ev[7]),
    .low_voltage_detector(ev[8]), .timer_match(ev[17:9]),
    .sub_clk(subdiv[1]), .stack_full(stack_full),
    .return_from_irq(ret), .irq_call(irq_call), .irq_vector(vec),
    .wakeup(wakeup));
  itb_core_model #(.RET_DELAY(30)) u_core (.hclk(hclk), .hresetn(hresetn),
    .hold_stack(hold), .irq_call(irq_call), .stack_full(stack_full),
    .return_from_irq(ret));

  always #25 hclk = ~hclk;

  // sub clock runs at a quarter of the system rate, unrelated to any frame
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    subdiv <= subdiv + 2'h1;
    if (wakeup === 1'b1)
      wake_cnt <= wake_cnt + 1;
    if (cycles == LIMIT)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= itb_pkg::HTRANS_NONSEQ;
    haddr <= {26'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, e);
  endtask

  task automatic pulse(input logic [17:0] m);
    @(posedge hclk);
    ev <= m;
    @(posedge hclk);
    ev <= 18'h0;
  endtask

  // irq_call stands one cycle, so it is looked at in mid-cycle
  task automatic wait_call(input int n, output logic h);
    h = 1'b0;
    repeat (n)
    begin
      @(negedge hclk);
      if (irq_call === 1'b1)
      begin
        h = 1'b1;
        break;
      end
    end
  endtask

  task automatic expect_call(input logic [3:0] v);
    logic h;
    wait_call(3000, h);
    check({h, vec}, {1'b1, v});
  endtask

  // second interval is measured, the first may start mid-count
  task automatic tb_run(input logic [5:0] a, input logic [31:0] c,
                        input logic [1:0] s, input logic [3:0] v,
                        input int p);
    int t0;
    wr(itb_pkg::OFS_PSC_SRC, {30'h0, s});
    wr(a, c);
    expect_call(v);
    t0 = cycles;
    expect_call(v);
    check(cycles - t0, p);
    rd_chk(itb_pkg::OFS_IRQ_FLAGS, 32'h0);
    wr(a, 32'h0);
  endtask

  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    check({hresp, phe}, 7'h2A);
    wr(itb_pkg::OFS_IRQ_CTRL, 32'h3F);
    wr(itb_pkg::OFS_PIN_EN, 32'h3F);
    wr(itb_pkg::OFS_AUX_EN, 32'h7FF);
    wr(itb_pkg::OFS_EDGE_SEL, 32'h555);
    foreach (rows[i])
    begin
      w0 = wake_cnt;
      pulse(rows[i].m);
      expect_call(rows[i].v);
      check(wake_cnt > w0, 1);
      rd_chk(itb_pkg::OFS_IRQ_FLAGS, rows[i].f);
      rd_chk(itb_pkg::OFS_AUX_FLAGS, rows[i].a);
      rd_chk(itb_pkg::OFS_IRQ_CTRL, 32'h3E);
      wr(itb_pkg::OFS_IRQ_FLAGS, 32'h1FFF);
      wr(itb_pkg::OFS_AUX_FLAGS, 32'h7FF);
      repeat (40) @(posedge hclk);
      rd_chk(itb_pkg::OFS_IRQ_CTRL, 32'h3F);
    end
    $display("source table test done");
    wr(itb_pkg::OFS_EDGE_SEL, 32'h558);
    pulse(18'h1);
    repeat (5) @(posedge hclk);
    rd_chk(itb_pkg::OFS_IRQ_FLAGS, 32'h0);
    pulse(18'h2);
    expect_call(4'h1);
    repeat (40) @(posedge hclk);
    wr(itb_pkg::OFS_EDGE_SEL, 32'h55B);
    @(posedge hclk);
    ev <= 18'h1;
    expect_call(4'h0);
    repeat (40) @(posedge hclk);
    ev <= 18'h0;
    expect_call(4'h0);
    repeat (40) @(posedge hclk);
    wr(itb_pkg::OFS_EDGE_SEL, 32'h555);
    fsel <= 6'h3E;
    pulse(18'h1);
    repeat (5) @(posedge hclk);
    rd_chk(itb_pkg::OFS_IRQ_FLAGS, 32'h0);
    fsel <= 6'h3F;
    $display("edge select test done");
    wr(itb_pkg::OFS_IRQ_CTRL, 32'h1F);
    w0 = wake_cnt;
    pulse(18'h40);
    wait_call(10, hit);
    check({hit, wake_cnt > w0}, 2'b01);
    hold <= 1'b1;
    wr(itb_pkg::OFS_IRQ_CTRL, 32'h3F);
    pulse(18'h1);
    wait_call(10, hit);
    check(hit, 1'b0);
    hold <= 1'b0;
    expect_call(4'h0);
    // the waiting call rises two cycles after the return, once the global enable is set again
    expect_call(4'h4);
    repeat (40) @(posedge hclk);
    rd_chk(itb_pkg::OFS_IRQ_FLAGS, 32'h0);
    // a pin edge while the clock enable is low must leave no trace
    ce <= 1'b0;
    pulse(18'h4);
    @(posedge hclk);
    ce <= 1'b1;
    rd_chk(itb_pkg::OFS_IRQ_FLAGS, 32'h0);
    $display("stack and priority test done");
    wr(itb_pkg::OFS_IRQ_CTRL, 32'hFF);
    tb_run(itb_pkg::OFS_TB0_CTRL, 32'h80, 2'h0, 4'h9, 256);
    tb_run(itb_pkg::OFS_TB0_CTRL, 32'h80, 2'h1, 4'h9, 1024);
    tb_run(itb_pkg::OFS_TB1_CTRL, 32'h81, 2'h0, 4'hA, 512);
    tb_run(itb_pkg::OFS_TB1_CTRL, 32'h81, 2'h2, 4'hA, 2048);
    $display("time base test done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(itb_pkg::OFS_TB1_CTRL, 32'h0);
    rd_chk(itb_pkg::OFS_PSC_SRC, 32'h0);
    wr(itb_pkg::OFS_PSC_SRC, 32'hFFFFFFFF);
    rd_chk(itb_pkg::OFS_PSC_SRC, 32'h3);
    wr(itb_pkg::OFS_TB0_CTRL, 32'hFFFFFFFF);
    rd_chk(itb_pkg::OFS_TB0_CTRL, 32'h87);
    rd_chk(6'h3C, 32'h0);
    $display("reset and register test done");
    report_and_stop();
  end
endmodule
